// [src/ccg_params.svh]
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH

// fixed upper nibble of the slave address; value is arbitrary
`define CCG_DEV_ID 4'hB

// register and command indices carried by the pointer byte
`define CCG_REG_DIV 8'h00
`define CCG_REG_STEP_HI 8'h01
`define CCG_REG_STEP_LO 8'h02
`define CCG_REG_BAND 8'h03
`define CCG_REG_ADDR 8'h04
`define CCG_REG_FBAND 8'h05
`define CCG_CMD_COMMIT 8'h06

// reset values of the writable registers
`define CCG_RST_DIV 8'h00
`define CCG_RST_STEP_HI 8'h00
`define CCG_RST_STEP_LO 8'h00
`define CCG_RST_BAND 5'h00
`define CCG_RST_ADDR 8'h00

// field positions
`define CCG_DIV_EXP_MSB 3
`define CCG_DITHER_BIT 4
`define CCG_DIV_EXP_MAX 4'h8
`define CCG_STEP_PAD 6
`define CCG_WC_BIT 3
`define CCG_ADDR_SEL_MSB 2
`define CCG_BAND_W 5

// bit counter landmarks inside one byte slot
`define CCG_BIT_LAST 4'h7
`define CCG_BIT_ACK 4'h8

// timing: link clear pulse must end well inside the start hold time
`define CCG_SYS_CLK_HZ 20000000
`define CCG_START_HOLD_NS 600
`define CCG_CLR_CYCLES (((`CCG_START_HOLD_NS * (`CCG_SYS_CLK_HZ / 1000000)) / 1000) / 3)

`endif

// [src/ccg_pkg.sv]
package ccg_pkg;

    typedef logic [7:0] ccg_byte_t;

    typedef enum logic [2:0] {
        ph_addr,
        ph_ptr,
        ph_wdata,
        ph_rdata,
        ph_ignore
    } ccg_phase_e;

endpackage

// [src/ccg_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

module ccg_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic clr,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

// [src/ccg_link_engine.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"

module ccg_link_engine
    import ccg_pkg::*;
#(
    parameter logic [3:0] DEV_ID = `CCG_DEV_ID
) (
    input wire logic scl_clk,
    input wire logic frame_clr,
    input wire logic link_rst,
    input wire logic sda_in,
    input wire logic [2:0] addr_sel,
    input wire logic nv_busy,
    input wire logic [7:0] rd_byte,
    output logic sda_oe_n,
    output logic wr_tgl,
    output logic [7:0] wr_byte,
    output logic wr_is_ptr,
    output logic rd_tgl
);

    logic [3:0] cfg_s;
    logic [2:0] addr_sel_s;
    logic busy_s;
    ccg_phase_e phase, next_phase;
    logic [3:0] cnt, next_cnt;
    ccg_byte_t shreg, next_shreg, rx_byte;
    logic ack, next_ack;
    logic next_wr_tgl, next_wr_is_ptr, next_rd_tgl;
    ccg_byte_t next_wr_byte;
    ccg_byte_t tx, next_tx;
    logic next_oe_n;
    logic [2:0] bit_idx;

    ccg_sync2 #(.W(4), .RST_VAL(4'h0)) u_cfg_sync (
        .clk(scl_clk),
        .clr(link_rst),
        .d({nv_busy, addr_sel}),
        .q(cfg_s)
    );
    assign busy_s = cfg_s[3];
    assign addr_sel_s = cfg_s[2:0];

    // receive side, sampled on the rising clock
    always_comb begin
        next_phase = phase;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ack = ack;
        next_wr_tgl = wr_tgl;
        next_wr_byte = wr_byte;
        next_wr_is_ptr = wr_is_ptr;
        next_rd_tgl = rd_tgl;
        rx_byte = {shreg[6:0], sda_in};
        if (cnt == `CCG_BIT_ACK) begin
            next_cnt = 4'h0;
            next_ack = 1'b0;
            if (phase == ph_rdata && !ack) begin
                if (sda_in) begin
                    next_phase = ph_ignore;
                end else begin
                    next_rd_tgl = !rd_tgl;
                end
            end
        end else begin
            next_shreg = rx_byte;
            next_cnt = cnt + 4'h1;
            if (cnt == `CCG_BIT_LAST) begin
                case (phase)
                    ph_addr: begin
                        if (rx_byte[7:4] == DEV_ID &&
                            rx_byte[3:1] == addr_sel_s) begin
                            if (busy_s) begin
                                next_phase = ph_ignore;
                            end else begin
                                next_ack = 1'b1;
                                next_phase = rx_byte[0] ? ph_rdata : ph_ptr;
                            end
                        end else begin
                            next_phase = ph_ignore;
                        end
                    end
                    ph_ptr, ph_wdata: begin
                        if (busy_s) begin
                            next_phase = ph_ignore;
                        end else begin
                            next_ack = 1'b1;
                            next_phase = ph_wdata;
                            next_wr_byte = rx_byte;
                            next_wr_is_ptr = (phase == ph_ptr);
                            next_wr_tgl = !wr_tgl;
                        end
                    end
                    default: begin
                        next_ack = 1'b0;
                    end
                endcase
            end
        end
    end

    // frame state is held cleared outside frames and at every start
    always_ff @(posedge scl_clk or posedge frame_clr) begin
        if (frame_clr) begin
            phase <= ph_addr;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ack <= 1'b0;
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ack <= next_ack;
        end
    end

    always_ff @(posedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            wr_tgl <= 1'b0;
            wr_byte <= 8'h00;
            wr_is_ptr <= 1'b0;
            rd_tgl <= 1'b0;
        end else begin
            wr_tgl <= next_wr_tgl;
            wr_byte <= next_wr_byte;
            wr_is_ptr <= next_wr_is_ptr;
            rd_tgl <= next_rd_tgl;
        end
    end

    // drive side, changes only on the falling clock
    always_comb begin
        next_oe_n = 1'b1;
        next_tx = tx;
        bit_idx = 3'(4'h7 - cnt);
        if (cnt == `CCG_BIT_ACK) begin
            next_oe_n = !ack;
        end else if (phase == ph_rdata) begin
            if (cnt == 4'h0) begin
                next_tx = rd_byte;
                next_oe_n = rd_byte[7];
            end else begin
                next_oe_n = tx[bit_idx];
            end
        end
    end

    always_ff @(negedge scl_clk or posedge frame_clr) begin
        if (frame_clr) begin
            sda_oe_n <= 1'b1;
            tx <= 8'h00;
        end else begin
            sda_oe_n <= next_oe_n;
            tx <= next_tx;
        end
    end

endmodule

`default_nettype wire

// [src/ccg_slave_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"

module ccg_slave_port
    import ccg_pkg::*;
#(
    parameter logic [3:0] DEV_ID = `CCG_DEV_ID
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [4:0] factory_band_code,
    input wire logic nv_busy,
    output logic nv_write_req,
    output logic [3:0] divide_exp,
    output logic dither_2pct,
    output logic [9:0] step_count,
    output logic [4:0] band_code,
    output logic [2:0] addr_select_bits,
    output logic manual_commit,
    output logic bus_active
);

    localparam logic [3:0] CLR_CYCLES = 4'(`CCG_CLR_CYCLES);

    // link crossing signals
    logic wr_tgl, wr_is_ptr, rd_tgl;
    ccg_byte_t wr_byte;
    logic [1:0] pin_s, tgl_s, tgl_d, next_tgl_d;
    logic scl_s, sda_s;
    logic [4:0] fband_s;

    // bus watch state
    logic scl_d, sda_d, next_scl_d, next_sda_d;
    logic in_frame, next_in_frame;
    logic [3:0] clr_cnt, next_clr_cnt;
    logic frame_clr, next_frame_clr;
    logic link_rst;
    logic start_cond, stop_cond;

    // register state
    ccg_byte_t div_raw, next_div_raw;
    logic [3:0] div_exp, next_div_exp;
    ccg_byte_t step_hi, next_step_hi;
    ccg_byte_t step_lo, next_step_lo;
    logic [4:0] band, next_band;
    ccg_byte_t addr_reg, next_addr_reg;
    ccg_byte_t ptr, next_ptr;
    ccg_byte_t rd_byte, next_rd_byte;
    logic nv_pend, next_nv_pend;
    logic nv_req, next_nv_req;
    logic busy_flag, next_busy_flag;
    logic wr_ev, rd_ev, nv_set, wr_hit, nv_issue;

    function automatic ccg_byte_t read_mux(
        input ccg_byte_t idx,
        input ccg_byte_t d_div,
        input ccg_byte_t d_hi,
        input ccg_byte_t d_lo,
        input logic [4:0] d_band,
        input ccg_byte_t d_addr,
        input logic [4:0] d_fband
    );
        ccg_byte_t r;
        r = 8'h00;
        if (idx == `CCG_REG_DIV) begin
            r = d_div;
        end else if (idx == `CCG_REG_STEP_HI) begin
            r = d_hi;
        end else if (idx == `CCG_REG_STEP_LO) begin
            r = d_lo;
        end else if (idx == `CCG_REG_BAND) begin
            r = {3'h0, d_band};
        end else if (idx == `CCG_REG_ADDR) begin
            r = d_addr;
        end else if (idx == `CCG_REG_FBAND) begin
            r = {3'h0, d_fband};
        end
        return r;
    endfunction

    function automatic logic [3:0] clamp_exp(input ccg_byte_t raw);
        logic [3:0] e;
        e = raw[`CCG_DIV_EXP_MSB:0];
        if (e > `CCG_DIV_EXP_MAX) begin
            e = `CCG_DIV_EXP_MAX;
        end
        return e;
    endfunction

    // pin sampling, idle level is high
    ccg_sync2 #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
        .clk(sys_clk),
        .clr(1'b0),
        .d({scl_in, sda_in}),
        .q(pin_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // event toggles from the link domain
    ccg_sync2 #(.W(2), .RST_VAL(2'b00)) u_tgl_sync (
        .clk(sys_clk),
        .clr(1'b0),
        .d({wr_tgl, rd_tgl}),
        .q(tgl_s)
    );

    // static factory copy still passes two stages before the read path
    ccg_sync2 #(.W(5), .RST_VAL(5'h00)) u_fband_sync (
        .clk(sys_clk),
        .clr(1'b0),
        .d(factory_band_code),
        .q(fband_s)
    );

    // serial engine on the master's clock; no clock output exists
    ccg_link_engine #(.DEV_ID(DEV_ID)) u_link (
        .scl_clk(scl_clk),
        .frame_clr(frame_clr),
        .link_rst(link_rst),
        .sda_in(sda_in),
        .addr_sel(addr_reg[`CCG_ADDR_SEL_MSB:0]),
        .nv_busy(busy_flag),
        .rd_byte(rd_byte),
        .sda_oe_n(sda_oe_n),
        .wr_tgl(wr_tgl),
        .wr_byte(wr_byte),
        .wr_is_ptr(wr_is_ptr),
        .rd_tgl(rd_tgl)
    );

    // start and stop detection, oversampled many times per bit
    always_comb begin
        start_cond = scl_s && scl_d && sda_d && !sda_s;
        stop_cond = scl_s && scl_d && !sda_d && sda_s;
        next_scl_d = scl_s;
        next_sda_d = sda_s;
        next_in_frame = in_frame;
        next_clr_cnt = clr_cnt;
        if (start_cond) begin
            next_in_frame = 1'b1;
            next_clr_cnt = CLR_CYCLES;
        end else begin
            if (stop_cond) begin
                next_in_frame = 1'b0;
            end
            if (clr_cnt != 4'h0) begin
                next_clr_cnt = clr_cnt - 4'h1;
            end
        end
        // link logic stays cleared while idle and briefly after each start
        next_frame_clr = !next_in_frame || (next_clr_cnt != 4'h0);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            in_frame <= 1'b0;
            clr_cnt <= 4'h0;
            frame_clr <= 1'b1;
            link_rst <= 1'b1;
        end else begin
            scl_d <= next_scl_d;
            sda_d <= next_sda_d;
            in_frame <= next_in_frame;
            clr_cnt <= next_clr_cnt;
            frame_clr <= next_frame_clr;
            link_rst <= 1'b0;
        end
    end

    // register file and nonvolatile write sequencing
    always_comb begin
        wr_ev = tgl_s[1] ^ tgl_d[1];
        rd_ev = tgl_s[0] ^ tgl_d[0];
        next_tgl_d = tgl_s;
        next_div_raw = div_raw;
        next_div_exp = div_exp;
        next_step_hi = step_hi;
        next_step_lo = step_lo;
        next_band = band;
        next_addr_reg = addr_reg;
        next_ptr = ptr;
        nv_set = 1'b0;
        wr_hit = 1'b0;
        if (wr_ev) begin
            if (wr_is_ptr) begin
                next_ptr = wr_byte;
                if (wr_byte == `CCG_CMD_COMMIT) begin
                    nv_set = 1'b1;
                end
            end else if (ptr == `CCG_REG_DIV) begin
                next_div_raw = wr_byte;
                next_div_exp = clamp_exp(wr_byte);
                wr_hit = 1'b1;
            end else if (ptr == `CCG_REG_STEP_HI) begin
                next_step_hi = wr_byte;
                next_ptr = `CCG_REG_STEP_LO;
                wr_hit = 1'b1;
            end else if (ptr == `CCG_REG_STEP_LO) begin
                next_step_lo = wr_byte & 8'hC0;
                wr_hit = 1'b1;
            end else if (ptr == `CCG_REG_BAND) begin
                next_band = wr_byte[`CCG_BAND_W-1:0];
                wr_hit = 1'b1;
            end else if (ptr == `CCG_REG_ADDR) begin
                next_addr_reg = wr_byte;
                nv_set = 1'b1;
            end
        end else if (rd_ev && ptr == `CCG_REG_STEP_HI) begin
            next_ptr = `CCG_REG_STEP_LO;
        end
        if (wr_hit && !addr_reg[`CCG_WC_BIT]) begin
            nv_set = 1'b1;
        end
        nv_issue = nv_pend && !nv_busy && !nv_req;
        next_nv_req = nv_issue;
        next_nv_pend = (nv_pend && !nv_issue) || nv_set;
        // busy seen by the link covers pending, issued and running writes
        next_busy_flag = nv_busy || nv_pend || nv_req || nv_set;
        // factory band copy is read-only, exposed for the master to read
        next_rd_byte = read_mux(
            next_ptr,
            next_div_raw,
            next_step_hi,
            next_step_lo,
            next_band,
            next_addr_reg,
            fband_s
        );
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tgl_d <= 2'b00;
            div_raw <= `CCG_RST_DIV;
            div_exp <= clamp_exp(`CCG_RST_DIV);
            step_hi <= `CCG_RST_STEP_HI;
            step_lo <= `CCG_RST_STEP_LO;
            band <= `CCG_RST_BAND;
            addr_reg <= `CCG_RST_ADDR;
            ptr <= `CCG_REG_DIV;
            rd_byte <= 8'h00;
            nv_pend <= 1'b0;
            nv_req <= 1'b0;
            busy_flag <= 1'b0;
            sda_out <= 1'b0;
            bus_active <= 1'b0;
        end else begin
            tgl_d <= next_tgl_d;
            div_raw <= next_div_raw;
            div_exp <= next_div_exp;
            step_hi <= next_step_hi;
            step_lo <= next_step_lo;
            band <= next_band;
            addr_reg <= next_addr_reg;
            ptr <= next_ptr;
            rd_byte <= next_rd_byte;
            nv_pend <= next_nv_pend;
            nv_req <= next_nv_req;
            busy_flag <= next_busy_flag;
            sda_out <= 1'b0;
            bus_active <= next_in_frame;
        end
    end

    assign nv_write_req = nv_req;
    assign divide_exp = div_exp;
    assign dither_2pct = div_raw[`CCG_DITHER_BIT];
    assign step_count = {step_hi, step_lo[7:`CCG_STEP_PAD]};
    assign band_code = band;
    assign addr_select_bits = addr_reg[`CCG_ADDR_SEL_MSB:0];
    assign manual_commit = addr_reg[`CCG_WC_BIT];

endmodule

`default_nettype wire

// [verification/ccg_port_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ccg_port_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic nv_busy,
    input wire logic nv_write_req,
    input wire logic [3:0] divide_exp,
    input wire logic [4:0] band_code,
    input wire logic [9:0] step_count,
    input wire logic [2:0] addr_select_bits,
    input wire logic bus_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    chk_open_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_start_seen: assert property (s_start |-> ##[1:8] bus_active)
        else $error("start not seen");
    chk_stop_seen: assert property (s_stop |-> ##[1:8] !bus_active)
        else $error("stop not seen");
    chk_idle_release: assert property (!bus_active && !$past(bus_active) |-> sda_oe_n)
        else $error("sda pulled on idle bus");
    chk_change_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda changed while scl high");
    chk_ack_hold: assert property (!sda_oe_n && $rose(scl_in) |-> (!sda_oe_n) [*8])
        else $error("low bit not held");
    chk_save_pulse: assert property (nv_write_req |-> !nv_busy ##1 !nv_write_req)
        else $error("bad save pulse");
    chk_exp_clamp: assert property (divide_exp <= 4'h8)
        else $error("exponent above 8");
    chk_cfg_frame: assert property ($changed(divide_exp) || $changed(band_code)
        || $changed(step_count) || $changed(addr_select_bits) |-> bus_active)
        else $error("setting changed outside a frame");
endmodule
bind ccg_slave_port ccg_port_chk i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .nv_busy(nv_busy),
    .nv_write_req(nv_write_req), .divide_exp(divide_exp), .band_code(band_code),
    .step_count(step_count), .addr_select_bits(addr_select_bits), .bus_active(bus_active));
`default_nettype wire

// [verification/ccg_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module ccg_bus_master (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    logic bclk;
    int h;
    // base clock of the master, free of the system clock phase
    initial begin
        bclk = 1'b0;
        scl = 1'b1;
        sda_pull = 1'b0;
        h = 39;
        #7;
        forever #16 bclk = ~bclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge bclk);
    endtask
    // begins from an idle bus, both lines high
    task automatic start();
        sda_pull <= 1'b1;
        tick(h);
        scl <= 1'b0;
    endtask
    task automatic rep_start();
        tick(h / 2);
        sda_pull <= 1'b0;
        tick(h / 2);
        scl <= 1'b1;
        tick(h);
        sda_pull <= 1'b1;
        tick(h);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(h / 2);
        sda_pull <= 1'b1;
        tick(h / 2);
        scl <= 1'b1;
        tick(h);
        sda_pull <= 1'b0;
        tick(h);
    endtask
    task automatic put_bit(input logic b, output logic r);
        tick(h / 2);
        sda_pull <= ~b;
        tick(h / 2);
        scl <= 1'b1;
        tick(h);
        r = sda;
        scl <= 1'b0;
    endtask
    // eight bits then the acknowledge slot; ninth high releases sda
    task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] q,
        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], a);
            q[i] = a;
        end
        put_bit(ninth, a);
        ack = ~a;
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module testbench
    import ccg_pkg::*;
;
    logic sys_clk, sys_rst, nv_busy, scl, sda_pull;
    wire logic sda;
    logic sda_out, sda_oe_n, nv_write_req, dither_2pct, manual_commit, bus_active;
    logic [3:0] divide_exp;
    logic [9:0] step_count;
    logic [4:0] band_code, fband;
    logic [2:0] addr_select_bits, cur_sel;
    logic [11:0] nv_cnt;
    int nv_pulses, errors, checks;
    ccg_byte_t dvals [4] = '{8'h1B, 8'h10, 8'h03, 8'h09};
    assign sda = ~sda_pull & (sda_oe_n | sda_out);
    ccg_bus_master i_mst (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    ccg_slave_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_clk(scl), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .factory_band_code(fband),
        .nv_busy(nv_busy), .nv_write_req(nv_write_req), .divide_exp(divide_exp),
        .dither_2pct(dither_2pct), .step_count(step_count), .band_code(band_code),
        .addr_select_bits(addr_select_bits), .manual_commit(manual_commit),
        .bus_active(bus_active));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // nonvolatile store: busy for a fixed time after each save request
    always @(posedge sys_clk) begin
        if (nv_write_req === 1'b1) begin
            nv_cnt <= 12'h5DC;
            nv_busy <= 1'b1;
            nv_pulses <= nv_pulses + 1;
        end else if (nv_cnt != 12'h000) begin
            nv_cnt <= nv_cnt - 12'h001;
            nv_busy <= (nv_cnt != 12'h001);
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic byte_chk(input ccg_byte_t d, input logic exp_ack);
        ccg_byte_t q;
        logic a;
        i_mst.xfer(d, 1'b1, q, a);
        `CHK("ack", exp_ack, a)
    endtask
    task automatic wr_reg(input ccg_byte_t p, input ccg_byte_t d0, input ccg_byte_t d1,
        input int n);
        i_mst.start();
        byte_chk({`CCG_DEV_ID, cur_sel, 1'b0}, 1'b1);
        byte_chk(p, 1'b1);
        if (n > 0) byte_chk(d0, 1'b1);
        if (n > 1) byte_chk(d1, 1'b1);
        i_mst.stop();
    endtask
    task automatic rd_reg(input ccg_byte_t p, input int n, output ccg_byte_t q0,
        output ccg_byte_t q1);
        logic a;
        i_mst.start();
        byte_chk({`CCG_DEV_ID, cur_sel, 1'b0}, 1'b1);
        byte_chk(p, 1'b1);
        i_mst.rep_start();
        byte_chk({`CCG_DEV_ID, cur_sel, 1'b1}, 1'b1);
        i_mst.xfer(8'hFF, n == 1, q0, a);
        if (n > 1) i_mst.xfer(8'hFF, 1'b1, q1, a);
        i_mst.stop();
        `CHK("bus_active", 1'b0, bus_active)
    endtask
    task automatic probe(input ccg_byte_t ab, input logic exp_ack);
        i_mst.start();
        byte_chk(ab, exp_ack);
        i_mst.stop();
        `CHK("bus_active", 1'b0, bus_active)
    endtask
    task automatic wait_nv();
        int i;
        i = 0;
        while (nv_busy !== 1'b0 && i < 4000) begin
            @(posedge sys_clk);
            i++;
        end
        if (i >= 4000) begin
            errors++;
            give_verdict();
        end
    endtask
    initial begin
        ccg_byte_t r0, r1;
        sys_rst = 1'b1;
        nv_busy = 1'b0;
        nv_cnt = 12'h000;
        nv_pulses = 0;
        errors = 0;
        checks = 0;
        fband = 5'h12;
        cur_sel = 3'h0;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        `CHK("oe_n", 1'b1, sda_oe_n)
        `CHK("reset_div", 5'h00, {divide_exp, dither_2pct})
        `CHK("reset_cfg", 19'h0, {step_count, band_code, manual_commit, addr_select_bits})
        wr_reg(`CCG_REG_ADDR, 8'h08, 8'h00, 1);
        `CHK("manual", 1'b1, manual_commit)
        probe({`CCG_DEV_ID, cur_sel, 1'b0}, 1'b0);
        `CHK("saves", 1, nv_pulses)
        wait_nv();
        foreach (dvals[k]) begin
            wr_reg(`CCG_REG_DIV, dvals[k], 8'h00, 1);
            `CHK("exp", (dvals[k][3:0] > 4'h8) ? 4'h8 : dvals[k][3:0], divide_exp)
            `CHK("dither", dvals[k][`CCG_DITHER_BIT], dither_2pct)
        end
        `CHK("saves", 1, nv_pulses)
        i_mst.h = 156;
        wr_reg(`CCG_REG_STEP_HI, 8'hA3, 8'hC0, 2);
        i_mst.h = 39;
        `CHK("step", {8'hA3, 8'hC0} >> `CCG_STEP_PAD, step_count)
        rd_reg(`CCG_REG_FBAND, 1, r0, r1);
        `CHK("fband", {3'h0, fband}, r0)
        wr_reg(`CCG_REG_BAND, r0 + 8'h01, 8'h00, 1);
        `CHK("band", fband + 5'h01, band_code)
        rd_reg(`CCG_REG_STEP_HI, 2, r0, r1);
        `CHK("step_hi", 8'hA3, r0)
        `CHK("step_lo", 8'hC0, r1)
        wr_reg(`CCG_REG_ADDR, 8'h0D, 8'h00, 1);
        `CHK("sel", 3'h5, addr_select_bits)
        wait_nv();
        probe({`CCG_DEV_ID, 3'h0, 1'b0}, 1'b0);
        probe({`CCG_DEV_ID ^ 4'h1, 3'h5, 1'b0}, 1'b0);
        cur_sel = 3'h5;
        wr_reg(`CCG_CMD_COMMIT, 8'h00, 8'h00, 0);
        `CHK("saves", 3, nv_pulses)
        wait_nv();
        rd_reg(`CCG_REG_BAND, 1, r0, r1);
        `CHK("band_rd", {3'h0, fband + 5'h01}, r0)
        give_verdict();
    end
endmodule
`default_nettype wire
